// ### iss_core.sv
// interrupt state-save registers with apb access and event interrupt
//
// Contract
// - interrupt take loads resume address register
// - resume point: earlier done, later not
// - faulting or next address per type
// - return fetches from saved resume address
// - status save captures, return restores state
// - high half specific, low half copied
// - machine check sets six cause flags
// - bit 30 cleared or copied per cause
// - external plus transfer error clears 30
// - machine check copies bits 16-29, 31
// - separate save pair for critical interrupts
// - machine check disabled enters checkstop
// - critical return loads next fetch address
module iss_core
  import iss_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        reset,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        take_valid,
  input  wire iss_pkg::iss_kind_t take_kind,
  input  wire logic [31:0] fault_address,
  input  wire logic [31:0] next_address,
  input  wire logic        save_next,
  input  wire logic [15:0] cause_info,
  input  wire logic [5:0]  mchk_causes,
  input  wire logic        return_normal,
  input  wire logic        return_critical,
  output logic             redirect_valid,
  output logic      [31:0] redirect_address,
  output logic      [31:0] machine_state,
  output logic             checkstop,
  output logic             irq
);
  import iss_pkg::*;

  typedef struct packed
  {
    logic [31:0]      resume;
    logic [31:0]      status;
    logic [31:0]      crit_resume;
    logic [31:0]      crit_status;
    logic [31:0]      mstate;
    logic [EVT_W-1:0] evt;
    logic [EVT_W-1:0] mask;
    logic             cstop;
    logic [31:0]      rdata;
    logic             ready;
    logic             err;
    logic             redir;
    logic [31:0]      redir_addr;
    logic             irq;
  } iss_state_t;

  iss_state_t state_reg;
  iss_state_t state_next;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // machine check status image; causes ordered icache..address parity
  function automatic logic [31:0] mchk_image(input logic [31:0] m, input logic [5:0] c);
    logic [31:0] s;
    s = m;
    s[31:16] = {10'h000, c};
    // only the external input alone keeps recoverability
    if (c[LSB_MCP-16] && !(c[LSB_IC_PARITY-16] || c[LSB_DC_PARITY-16] || c[LSB_TEA-16]
        || c[LSB_DPE-16] || c[LSB_APE-16]))
      s[LSB_RI] = m[LSB_RI];
    else
      s[LSB_RI] = 1'b0;
    return s;
  endfunction : mchk_image

  function automatic logic [31:0] reg_read(input iss_state_t s, input logic [7:0] a);
    logic [31:0] d;
    d = 32'h0000_0000;
    case (a)
      ADDR_RESUME:      d = s.resume;
      ADDR_STATUS:      d = s.status;
      ADDR_CRIT_RESUME: d = s.crit_resume;
      ADDR_CRIT_STATUS: d = s.crit_status;
      ADDR_MSTATE:      d = s.mstate;
      ADDR_EVT_STATUS:  d = {28'h0000000, s.evt};
      ADDR_EVT_MASK:    d = {28'h0000000, s.mask};
      ADDR_CONTROL:     d = {31'h00000000, s.cstop};
      default:          d = 32'h0000_0000;
    endcase
    return d;
  endfunction : reg_read

  function automatic logic addr_ok(input logic [7:0] a);
    return (a[1:0] == 2'h0) && (a <= ADDR_CONTROL);
  endfunction : addr_ok

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  logic             bus_wr;
  logic             bus_rd;
  logic [EVT_W-1:0] evt_set;
  logic             take_go;

  always_comb
  begin
    state_next = state_reg;
    bus_wr = psel && penable && !state_reg.ready && pwrite;
    bus_rd = psel && penable && !state_reg.ready && !pwrite;
    evt_set = '0;
    // a stopped core takes nothing further until reset
    take_go = take_valid && !state_reg.cstop;

    // software writes first; hardware capture below overrides same cycle
    if (bus_wr && addr_ok(paddr))
    begin
      case (paddr)
        ADDR_RESUME:      state_next.resume = pwdata;
        ADDR_STATUS:      state_next.status = pwdata;
        ADDR_CRIT_RESUME: state_next.crit_resume = pwdata;
        ADDR_CRIT_STATUS: state_next.crit_status = pwdata;
        ADDR_MSTATE:      state_next.mstate = pwdata;
        ADDR_EVT_STATUS:  state_next.evt = state_reg.evt & ~pwdata[EVT_W-1:0];
        ADDR_EVT_MASK:    state_next.mask = pwdata[EVT_W-1:0];
        default:          state_next.cstop = state_reg.cstop;
      endcase
    end

    if (take_go)
    begin
      case (take_kind)
        ISS_KIND_MCHK:
        begin
          if (state_reg.mstate[LSB_MCHK_EN])
          begin
            state_next.resume = fault_address;
            state_next.status = mchk_image(state_reg.mstate, mchk_causes);
            evt_set[EVT_MCHK] = 1'b1;
            evt_set[EVT_TAKEN] = 1'b1;
          end
          else
          begin
            state_next.cstop = 1'b1;
            evt_set[EVT_CSTOP] = 1'b1;
          end
        end
        ISS_KIND_CRIT:
        begin
          state_next.crit_resume = save_next ? next_address : fault_address;
          state_next.crit_status = state_reg.mstate;
          evt_set[EVT_CRIT] = 1'b1;
        end
        default:
        begin
          state_next.resume = save_next ? next_address : fault_address;
          state_next.status = {cause_info, state_reg.mstate[15:0]};
          evt_set[EVT_TAKEN] = 1'b1;
        end
      endcase
    end

    // set wins over a same-cycle write-one clear
    state_next.evt = state_next.evt | evt_set;

    state_next.redir = 1'b0;
    if (return_critical && !take_go)
    begin
      state_next.redir = 1'b1;
      state_next.redir_addr = state_reg.crit_resume;
      state_next.mstate = state_reg.crit_status;
    end
    else if (return_normal && !take_go)
    begin
      state_next.redir = 1'b1;
      state_next.redir_addr = state_reg.resume;
      state_next.mstate = state_reg.status;
    end

    state_next.ready = psel && penable && !state_reg.ready;
    state_next.err = (bus_wr || bus_rd) && !addr_ok(paddr);
    state_next.rdata = bus_rd ? reg_read(state_reg, paddr) : 32'h0000_0000;
    state_next.irq = |(state_next.evt & state_next.mask);
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      state_reg.resume      <= RST_WORD;
      state_reg.status      <= RST_WORD;
      state_reg.crit_resume <= RST_WORD;
      state_reg.crit_status <= RST_WORD;
      state_reg.mstate      <= RST_MSTATE;
      state_reg.evt         <= '0;
      state_reg.mask        <= '0;
      state_reg.cstop       <= 1'b0;
      state_reg.rdata       <= RST_WORD;
      state_reg.ready       <= 1'b0;
      state_reg.err         <= 1'b0;
      state_reg.redir       <= 1'b0;
      state_reg.redir_addr  <= RST_WORD;
      state_reg.irq         <= 1'b0;
    end
    else
      state_reg <= state_next;
  end

  assign prdata           = state_reg.rdata;
  assign pready           = state_reg.ready;
  assign pslverr          = state_reg.err;
  assign redirect_valid   = state_reg.redir;
  assign redirect_address = state_reg.redir_addr;
  assign machine_state    = state_reg.mstate;
  assign checkstop        = state_reg.cstop;
  assign irq              = state_reg.irq;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  property p_resume_load;
    @(posedge clock) disable iff (reset)
    take_go && take_kind == ISS_KIND_NORMAL |=>
      state_reg.resume == ($past(save_next) ? $past(next_address) : $past(fault_address));
  endproperty
  a_resume_load: assert property (p_resume_load) else $error("resume not loaded");

  property p_status_high;
    @(posedge clock) disable iff (reset)
    take_go && take_kind == ISS_KIND_NORMAL |=>
      state_reg.status == {$past(cause_info), $past(state_reg.mstate[15:0])};
  endproperty
  a_status_high: assert property (p_status_high) else $error("status image wrong");

  property p_mchk_flags;
    @(posedge clock) disable iff (reset)
    take_go && take_kind == ISS_KIND_MCHK && state_reg.mstate[LSB_MCHK_EN] |=>
      state_reg.status[31:16] == {10'h000, $past(mchk_causes)};
  endproperty
  a_mchk_flags: assert property (p_mchk_flags) else $error("machine check flags wrong");

  property p_mchk_ri;
    @(posedge clock) disable iff (reset)
    take_go && take_kind == ISS_KIND_MCHK && state_reg.mstate[LSB_MCHK_EN]
      && mchk_causes[LSB_TEA-16] |=> !state_reg.status[LSB_RI];
  endproperty
  a_mchk_ri: assert property (p_mchk_ri) else $error("recoverable bit kept");

  property p_checkstop;
    @(posedge clock) disable iff (reset)
    take_go && take_kind == ISS_KIND_MCHK && !state_reg.mstate[LSB_MCHK_EN] |=>
      checkstop && $stable(state_reg.status);
  endproperty
  a_checkstop: assert property (p_checkstop) else $error("no checkstop");

  property p_return;
    @(posedge clock) disable iff (reset)
    return_normal && !return_critical && !take_go |=>
      redirect_valid && redirect_address == $past(state_reg.resume)
      && machine_state == $past(state_reg.status);
  endproperty
  a_return: assert property (p_return) else $error("return wrong");

  property p_crit_return;
    @(posedge clock) disable iff (reset)
    return_critical && !take_go |=> redirect_address == $past(state_reg.crit_resume);
  endproperty
  a_crit_return: assert property (p_crit_return) else $error("critical return wrong");

  property p_crit_pair;
    @(posedge clock) disable iff (reset)
    take_go && take_kind == ISS_KIND_CRIT |=>
      state_reg.crit_status == $past(state_reg.mstate) && $stable(state_reg.resume);
  endproperty
  a_crit_pair: assert property (p_crit_pair) else $error("critical pair wrong");

  property p_mchk_keep;
    @(posedge clock) disable iff (reset)
    take_go && take_kind == ISS_KIND_MCHK && state_reg.mstate[LSB_MCHK_EN]
      && mchk_causes == 6'h08 |=> state_reg.status[LSB_RI] == $past(state_reg.mstate[LSB_RI]);
  endproperty
  a_mchk_keep: assert property (p_mchk_keep) else $error("recoverable bit lost");

  property p_mchk_copy;
    @(posedge clock) disable iff (reset)
    take_go && take_kind == ISS_KIND_MCHK && state_reg.mstate[LSB_MCHK_EN] |=>
      state_reg.resume == $past(fault_address)
      && state_reg.status[15:2] == $past(state_reg.mstate[15:2])
      && state_reg.status[0] == $past(state_reg.mstate[0]);
  endproperty
  a_mchk_copy: assert property (p_mchk_copy) else $error("machine check copy wrong");

  // a stopped core must leave both save registers alone
  property p_cstop_refuse;
    @(posedge clock) disable iff (reset)
    checkstop && take_valid && !(psel && penable) |=>
      checkstop && $stable(state_reg.resume) && $stable(state_reg.status);
  endproperty
  a_cstop_refuse: assert property (p_cstop_refuse) else $error("take after checkstop");

endmodule : iss_core

// ### iss_pkg.sv
// constants for the interrupt state-save block
package iss_pkg;

  // ---------------------------------------------------------------
  // register map (byte offsets)
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_RESUME      = 8'h00;
  localparam logic [7:0] ADDR_STATUS      = 8'h04;
  localparam logic [7:0] ADDR_CRIT_RESUME = 8'h08;
  localparam logic [7:0] ADDR_CRIT_STATUS = 8'h0c;
  localparam logic [7:0] ADDR_MSTATE      = 8'h10;
  localparam logic [7:0] ADDR_EVT_STATUS  = 8'h14;
  localparam logic [7:0] ADDR_EVT_MASK    = 8'h18;
  localparam logic [7:0] ADDR_CONTROL     = 8'h1c;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [31:0] RST_WORD   = 32'h0000_0000;
  localparam logic [31:0] RST_MSTATE = 32'h0000_1000;

  // ---------------------------------------------------------------
  // field positions (bit 0 is the most significant bit, 31 the least)
  // ---------------------------------------------------------------
  localparam int LSB_IC_PARITY = 31 - 10;
  localparam int LSB_DC_PARITY = 31 - 11;
  localparam int LSB_MCP       = 31 - 12;
  localparam int LSB_TEA       = 31 - 13;
  localparam int LSB_DPE       = 31 - 14;
  localparam int LSB_APE       = 31 - 15;
  localparam int LSB_RI        = 31 - 30;
  localparam int LSB_MCHK_EN   = 31 - 19;

  // event status bits
  localparam int EVT_TAKEN = 0;
  localparam int EVT_MCHK  = 1;
  localparam int EVT_CSTOP = 2;
  localparam int EVT_CRIT  = 3;
  localparam int EVT_W     = 4;

  // interrupt kinds
  typedef enum logic [1:0]
  {
    ISS_KIND_NORMAL = 2'h0,
    ISS_KIND_MCHK   = 2'h1,
    ISS_KIND_CRIT   = 2'h2
  } iss_kind_t;

endpackage : iss_pkg

// ### iss_pipe_model.sv
// core pipeline model: raises interrupt takes and returns, follows fetch redirects
module iss_pipe_model
  import iss_pkg::*;
(
  input  wire logic        clock,
  output logic             take_valid,
  output iss_pkg::iss_kind_t take_kind,
  output logic      [31:0] fault_address,
  output logic      [31:0] next_address,
  output logic             save_next,
  output logic      [15:0] cause_info,
  output logic      [5:0]  mchk_causes,
  output logic             return_normal,
  output logic             return_critical,
  input  wire logic        redirect_valid,
  input  wire logic [31:0] redirect_address,
  output logic      [31:0] fetch_pc
);
  initial
  begin
    take_valid = 1'b0;
    take_kind = ISS_KIND_NORMAL;
    {fault_address, next_address, save_next, cause_info, mchk_causes} = '0;
    return_normal = 1'b0;
    return_critical = 1'b0;
  end

  // fetch restarts wherever the block points it
  always_ff @(posedge clock)
    if (redirect_valid) fetch_pc <= redirect_address;

  task automatic take(input iss_kind_t k, input logic [31:0] fa, input logic [31:0] na,
                      input logic sn, input logic [15:0] ci, input logic [5:0] mc);
    @(posedge clock);
    take_valid <= 1'b1;
    take_kind <= k;
    fault_address <= fa;
    next_address <= na;
    save_next <= sn;
    cause_info <= ci;
    mchk_causes <= mc;
    @(posedge clock);
    take_valid <= 1'b0;
    // stale addresses must not look valid after the take
    fault_address <= ~fa;
    next_address <= ~na;
  endtask : take

  task automatic ret(input logic crit);
    @(posedge clock);
    return_normal <= !crit;
    return_critical <= crit;
    @(posedge clock);
    return_normal <= 1'b0;
    return_critical <= 1'b0;
  endtask : ret
endmodule : iss_pipe_model

// ### iss_core_tb.sv
// self-checking bench for the interrupt state-save block
module iss_core_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import iss_pkg::*;

  logic        clock, reset, psel, penable, pwrite, pready, pslverr, irq, checkstop, e;
  logic        take_valid, save_next, return_normal, return_critical, redirect_valid;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, redirect_address, machine_state, fetch_pc, q, fa;
  logic [31:0] fault_address, next_address;
  logic [15:0] cause_info;
  logic [5:0]  mchk_causes, mc;
  iss_kind_t   take_kind;
  int          failures = 0;
  int          compares = 0;

  iss_core dut (.clock, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .take_valid, .take_kind, .fault_address, .next_address, .save_next, .cause_info,
    .mchk_causes, .return_normal, .return_critical, .redirect_valid, .redirect_address,
    .machine_state, .checkstop, .irq);
  iss_pipe_model pipe (.clock, .take_valid, .take_kind, .fault_address, .next_address,
    .save_next, .cause_info, .mchk_causes, .return_normal, .return_critical, .redirect_valid,
    .redirect_address, .fetch_pc);

  // ----------------------------------------
  // bus and compare tasks
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      failures++;
      $display("[ERR] %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rq, output logic re);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    // no local limit: only the watchdog ends a hung wait
    do
    begin
      @(posedge clock);
    end
    while (pready !== 1'b1);
    rq = prdata;
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0, q, e);
    check(q, x);
  endtask : rd

  task automatic take_chk(input iss_kind_t k, input logic [31:0] ms, input logic [31:0] f,
                          input logic sn, input logic [15:0] ci, input logic [5:0] m,
                          input logic [7:0] ra, input logic [31:0] er, input logic [31:0] es);
    apb(1'b1, ADDR_MSTATE, ms, q, e);
    pipe.take(k, f, f + 32'h4, sn, ci, m);
    @(posedge clock);
    rd(ra, er);
    rd(ra + 8'h04, es);
  endtask : take_chk

  task automatic ret_chk(input logic crit, input logic [31:0] pc, input logic [31:0] ms);
    pipe.ret(crit);
    @(posedge clock);
    #1;
    check(fetch_pc, pc);
    check(machine_state, ms);
  endtask : ret_chk

  task automatic test_done;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : test_done

  // ----------------------------------------
  // clock, watchdog and tests
  // ----------------------------------------
  initial
  begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  // whole run needs well under a thousand cycles
  initial
  begin
    repeat (20000) @(posedge clock);
    failures++;
    test_done;
  end

  initial
  begin
    {reset, psel, penable, pwrite, paddr, pwdata} = {1'b1, 43'h0};
    repeat (8) @(posedge clock);
    reset <= 1'b0;
    rd(ADDR_RESUME, RST_WORD);
    rd(ADDR_CRIT_STATUS, RST_WORD);
    rd(ADDR_MSTATE, RST_MSTATE);
    apb(1'b0, 8'h20, 32'h0, q, e);
    check({31'h0, e}, 32'h1);
    check({31'h0, irq}, 32'h0);
    $display("test reset done");
    take_chk(ISS_KIND_NORMAL, 32'h0000_d5a3, 32'h0000_1100, 1'b1, 16'ha5c3, 6'h3f,
      ADDR_RESUME, 32'h0000_1104, 32'ha5c3_d5a3);
    take_chk(ISS_KIND_NORMAL, 32'h0000_d5a3, 32'h0000_1100, 1'b0, 16'h5a3c, 6'h00,
      ADDR_RESUME, 32'h0000_1100, 32'h5a3c_d5a3);
    ret_chk(1'b0, 32'h0000_1100, 32'h5a3c_d5a3);
    $display("test normal done");
    // six single causes, then external with transfer error together
    for (int i = 0; i < 7; i++)
    begin
      mc = (i < 6) ? 6'h01 << i : 6'h0c;
      fa = 32'h0000_4000 + 32'(i * 16);
      take_chk(ISS_KIND_MCHK, 32'h0000_d5a3, fa, 1'b1, 16'hffff, mc, ADDR_RESUME, fa,
        {10'h0, mc, 14'h3568, (mc == 6'h08), 1'b1});
    end
    $display("test machine check done");
    take_chk(ISS_KIND_CRIT, 32'h0000_9ab3, 32'h0000_3300, 1'b0, 16'h0, 6'h0,
      ADDR_CRIT_RESUME, 32'h0000_3300, 32'h0000_9ab3);
    rd(ADDR_RESUME, 32'h0000_4060);
    ret_chk(1'b1, 32'h0000_3300, 32'h0000_9ab3);
    ret_chk(1'b0, 32'h0000_4060, 32'h000c_d5a1);
    $display("test critical done");
    rd(ADDR_EVT_STATUS, 32'h0000_000b);
    apb(1'b1, ADDR_EVT_MASK, 32'h0000_0008, q, e);
    @(posedge clock);
    #1;
    check({31'h0, irq}, 32'h1);
    apb(1'b1, ADDR_EVT_STATUS, 32'h0000_0008, q, e);
    @(posedge clock);
    #1;
    check({31'h0, irq}, 32'h0);
    rd(ADDR_EVT_STATUS, 32'h0000_0003);
    $display("test events done");
    // first take lands in checkstop, second must be refused
    repeat (2) take_chk(ISS_KIND_MCHK, 32'h0000_0003, 32'h0000_5000, 1'b0, 16'h0, 6'h08,
      ADDR_RESUME, 32'h0000_4060, 32'h000c_d5a1);
    check({31'h0, checkstop}, 32'h1);
    rd(ADDR_CONTROL, 32'h0000_0001);
    $display("test checkstop done");
    test_done;
  end
endmodule : iss_core_tb
